/* inc/ipsel_defs.svh */
// Purpose: constants for the boot-time network address selector
// Assumes: 25 MHz system clock
// Notes: mode values a..f, address constants and base timing live here; name-mode limit, settle and blink counts and register offsets are in ipsel_top
`ifndef IPSEL_DEFS_SVH
`define IPSEL_DEFS_SVH
// ==========================================================
// mode switch decode points
`define IPSEL_MODE_BOOTP_A 4'ha
`define IPSEL_MODE_BOOTP_B 4'hb
`define IPSEL_MODE_FALLBACK 4'hc
`define IPSEL_MODE_STORED 4'hd
`define IPSEL_MODE_ERASE 4'he
`define IPSEL_MODE_MACDER 4'hf
// ==========================================================
// address constants
`define IPSEL_NET_PREFIX 24'hc0a864
`define IPSEL_NET_MASK 32'hffffff00
`define IPSEL_LAST_MIN 8'h01
`define IPSEL_LAST_MAX 8'h9f
`define IPSEL_MAC_LOW_SUB 8'h01
`define IPSEL_MAC_HIGH_SUB 8'hfe
`define IPSEL_MODBUS_PORT 16'h01f6
// ==========================================================
// timing
`define IPSEL_CLK_HZ 32'd25000000
`define IPSEL_DHCP_WAIT_S 32'd120
`define IPSEL_DHCP_WAIT_CYC (`IPSEL_DHCP_WAIT_S * `IPSEL_CLK_HZ)
`define IPSEL_BLINK_MS 32'd250
`define IPSEL_BLINK_CYC (`IPSEL_BLINK_MS * (`IPSEL_CLK_HZ / 1000))
// ==========================================================
// status and mask bit positions
`define IPSEL_EV_ADDR_OK 0
`define IPSEL_EV_FALLBACK 1
`define IPSEL_EV_CONFLICT 2
`define IPSEL_EV_SW_CHANGE 3
`define IPSEL_EV_W 4
`endif

/* inc/ipsel_pkg.sv */
// Purpose: types for the boot-time network address selector
// Assumes: nothing beyond the defs header
// Notes: state machine, led patterns and address bundle
package ipsel_pkg;
  // ==========================================================
  // address selection states, one-hot
  typedef enum logic [6:0] {
    IPSEL_ST_SAMPLE = 7'h01, // wait for switch sync
    IPSEL_ST_NAME = 7'h02, // dhcp keyed by label
    IPSEL_ST_MAC = 7'h04, // dhcp or bootp keyed by mac
    IPSEL_ST_FALLBK = 7'h08, // dhcp then stored
    IPSEL_ST_STORED = 7'h10, // stored parameters
    IPSEL_ST_ERASE = 7'h20, // erase, manual last byte
    IPSEL_ST_MACDER = 7'h40 // derived from mac
  } ipsel_state_type;
  // led indications
  typedef enum logic [2:0] {
    IPSEL_LED_OFF = 3'h0,
    IPSEL_LED_ON = 3'h1,
    IPSEL_LED_FLASH2 = 3'h2,
    IPSEL_LED_FLASH4 = 3'h4
  } ipsel_led_type;
  // applied address set
  typedef struct packed {
    logic [31:0] addr; // host address
    logic [31:0] mask; // net mask
    logic [31:0] gw; // gateway
    logic valid; // set is usable
  } ipsel_cfg_type;
  // dhcp request to the stack
  typedef struct packed {
    logic req; // ask the server
    logic by_label; // use host label not mac
    logic [23:0] label_digits; // three ascii digits
  } ipsel_dhcp_type;
endpackage : ipsel_pkg

/* hdl/ipsel_top.sv */
// Purpose: boot-time network address selection from two rotary switches
// Assumes: switches are asynchronous pins; stack and nvm are same-clock logic
// Notes: the mode is latched once after reset and held until power cycle
`timescale 1ns/1ps
`default_nettype none
`include "ipsel_defs.svh"
module ipsel_top #(
  parameter int unsigned DHCP_WAIT_CYC = `IPSEL_DHCP_WAIT_CYC, // fallback wait
  parameter int unsigned BLINK_CYC = `IPSEL_BLINK_CYC // led phase length
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] mode_select_switch, // pin, asynchronous
  input wire logic [3:0] tens_digit_switch, // pin, asynchronous
  input wire logic [7:0] mac_last_byte, // factory mac, low byte
  input wire ipsel_pkg::ipsel_cfg_type nvm_cfg, // stored parameters
  input wire logic dhcp_ack, // server answered
  input wire logic [31:0] dhcp_addr, // offered address
  input wire logic [31:0] dhcp_mask, // offered mask
  input wire logic [31:0] dhcp_gw, // offered gateway
  input wire logic addr_conflict, // duplicate address seen
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output ipsel_pkg::ipsel_dhcp_type dhcp_req, // request to stack
  output ipsel_pkg::ipsel_cfg_type cfg_out, // applied address set
  output logic nvm_erase, // erase stored set, one pulse
  output logic [15:0] modbus_port, // listening port
  output logic status_led, // drive for status led
  output logic irq // level interrupt
);
  import ipsel_pkg::*;

  // ==========================================================
  // register offsets (word addressed by byte)
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0c;
  localparam logic [7:0] OFS_SWCFG = 8'h10;

  // ==========================================================
  // all state in one struct
  typedef struct packed {
    logic [3:0] m_sync1; // mode sync stage 1
    logic [3:0] m_sync2; // mode sync stage 2
    logic [3:0] t_sync1; // tens sync stage 1
    logic [3:0] t_sync2; // tens sync stage 2
    logic [1:0] settle; // sync fill count
    ipsel_state_type st; // selection state
    logic [3:0] mode_lat; // latched mode
    logic [3:0] tens_lat; // latched tens
    logic [7:0] sw_val; // last switch-derived byte
    logic [31:0] wait_cnt; // dhcp fallback timer
    logic [31:0] blink_cnt; // led phase timer
    logic [3:0] blink_ph; // led phase index
    ipsel_led_type led; // current indication
    logic led_o; // led output
    logic conflict; // duplicate seen
    logic erase_ready; // erase mode reached steady
    ipsel_cfg_type cfg; // applied set
    ipsel_dhcp_type dreq; // request to stack
    logic erase_p; // erase pulse
    logic [31:0] sw_cfg; // software pending address
    logic [`IPSEL_EV_W-1:0] stat; // sticky events
    logic [`IPSEL_EV_W-1:0] mask; // interrupt mask
    logic [31:0] rdata; // read data
    logic irq_o; // interrupt output
  } ipsel_regs_type;

  ipsel_regs_type q_r;
  ipsel_regs_type q_nxt;

  // ==========================================================
  // helpers
  // ascii digits of a byte, hundreds first
  function automatic logic [23:0] to_ascii(input logic [7:0] v);
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] u;
    h = v / 8'd100;
    t = (v % 8'd100) / 8'd10;
    u = v % 8'd10;
    to_ascii = {8'h30 + h, 8'h30 + t, 8'h30 + u};
  endfunction : to_ascii

  // 10 * tens + mode, both nibbles
  function automatic logic [7:0] sw_byte(input logic [3:0] tens, input logic [3:0] md);
    logic [7:0] r;
    r = 8'({tens, 3'h0}) + 8'({tens, 1'h0}) + 8'(md);
    sw_byte = r;
  endfunction : sw_byte

  // ==========================================================
  // next-state logic
  always_comb begin
    logic [7:0] live_byte;
    logic [7:0] host;
    logic [`IPSEL_EV_W-1:0] ev;
    live_byte = 8'h00;
    host = 8'h00;
    ev = '0;
    q_nxt = q_r;
    q_nxt.erase_p = 1'b0;
    // double-flop switch pins; stage 1 feeds only stage 2
    q_nxt.m_sync1 = mode_select_switch;
    q_nxt.m_sync2 = q_r.m_sync1;
    q_nxt.t_sync1 = tens_digit_switch;
    q_nxt.t_sync2 = q_r.t_sync1;
    live_byte = sw_byte(q_r.t_sync2, q_r.m_sync2);
    if (addr_conflict) begin
      q_nxt.conflict = 1'b1;
      ev[`IPSEL_EV_CONFLICT] = ~q_r.conflict;
    end
    case (q_r.st)
      IPSEL_ST_SAMPLE: begin
        // wait until synchronised values are trustworthy
        if (q_r.settle != 2'h3) begin
          q_nxt.settle = q_r.settle + 2'h1;
        end else begin
          q_nxt.mode_lat = q_r.m_sync2;
          q_nxt.tens_lat = q_r.t_sync2;
          q_nxt.sw_val = live_byte;
          if (q_r.m_sync2 <= 4'h9) begin
            q_nxt.st = IPSEL_ST_NAME;
            q_nxt.dreq.req = 1'b1;
            q_nxt.dreq.by_label = 1'b1;
            q_nxt.dreq.label_digits = to_ascii(live_byte);
          end else if (q_r.m_sync2 == `IPSEL_MODE_BOOTP_A
                       || q_r.m_sync2 == `IPSEL_MODE_BOOTP_B) begin
            q_nxt.st = IPSEL_ST_MAC;
            q_nxt.dreq.req = 1'b1;
            q_nxt.dreq.by_label = 1'b0;
          end else if (q_r.m_sync2 == `IPSEL_MODE_FALLBACK) begin
            q_nxt.st = IPSEL_ST_FALLBK;
            q_nxt.dreq.req = 1'b1;
            q_nxt.dreq.by_label = 1'b0;
            q_nxt.wait_cnt = '0;
          end else if (q_r.m_sync2 == `IPSEL_MODE_STORED) begin
            q_nxt.st = IPSEL_ST_STORED;
            q_nxt.cfg = nvm_cfg;
          end else if (q_r.m_sync2 == `IPSEL_MODE_ERASE) begin
            q_nxt.st = IPSEL_ST_ERASE;
            q_nxt.erase_p = 1'b1;
            q_nxt.cfg.addr = {`IPSEL_NET_PREFIX, 8'h00};
            q_nxt.cfg.mask = `IPSEL_NET_MASK;
            q_nxt.cfg.gw = {`IPSEL_NET_PREFIX, 8'h00};
            q_nxt.cfg.valid = 1'b0;
          end else begin
            q_nxt.st = IPSEL_ST_MACDER;
            if (mac_last_byte == 8'h00) begin
              host = `IPSEL_MAC_LOW_SUB;
            end else if (mac_last_byte == 8'hff) begin
              host = `IPSEL_MAC_HIGH_SUB;
            end else begin
              host = mac_last_byte;
            end
            q_nxt.cfg.addr = {`IPSEL_NET_PREFIX, host};
            q_nxt.cfg.mask = `IPSEL_NET_MASK;
            q_nxt.cfg.gw = {`IPSEL_NET_PREFIX, host};
            q_nxt.cfg.valid = 1'b1;
            ev[`IPSEL_EV_ADDR_OK] = 1'b1;
          end
        end
      end
      IPSEL_ST_NAME, IPSEL_ST_MAC: begin
        // server answer completes the request
        if (q_r.dreq.req && dhcp_ack) begin
          q_nxt.dreq.req = 1'b0;
          q_nxt.cfg = '{addr: dhcp_addr, mask: dhcp_mask, gw: dhcp_gw, valid: 1'b1};
          ev[`IPSEL_EV_ADDR_OK] = 1'b1;
        end
      end
      IPSEL_ST_FALLBK: begin
        if (q_r.dreq.req) begin
          if (dhcp_ack) begin
            q_nxt.dreq.req = 1'b0;
            q_nxt.cfg = '{addr: dhcp_addr, mask: dhcp_mask, gw: dhcp_gw, valid: 1'b1};
            ev[`IPSEL_EV_ADDR_OK] = 1'b1;
          end else if (q_r.wait_cnt >= DHCP_WAIT_CYC - 1) begin
            // no server within the window: give up and use the store
            q_nxt.dreq.req = 1'b0;
            q_nxt.cfg = nvm_cfg;
            ev[`IPSEL_EV_FALLBACK] = 1'b1;
          end else begin
            q_nxt.wait_cnt = q_r.wait_cnt + 32'h1;
          end
        end
      end
      IPSEL_ST_ERASE: begin
        // last byte follows the switches live
        if (live_byte != q_r.sw_val) begin
          q_nxt.sw_val = live_byte;
          q_nxt.erase_ready = 1'b0;
          ev[`IPSEL_EV_SW_CHANGE] = 1'b1;
        end else if (!q_r.erase_ready && live_byte >= `IPSEL_LAST_MIN
                     && live_byte <= `IPSEL_LAST_MAX) begin
          q_nxt.erase_ready = 1'b1;
          q_nxt.cfg.addr = {`IPSEL_NET_PREFIX, live_byte};
          q_nxt.cfg.gw = {`IPSEL_NET_PREFIX, live_byte};
          q_nxt.cfg.valid = 1'b1;
          ev[`IPSEL_EV_ADDR_OK] = 1'b1;
        end
        if (q_r.erase_ready && live_byte != q_r.sw_val) begin
          q_nxt.cfg.valid = 1'b0;
        end
      end
      IPSEL_ST_STORED, IPSEL_ST_MACDER: begin
        // fixed until power cycle
      end
      default: begin
        q_nxt.st = IPSEL_ST_SAMPLE;
      end
    endcase
    // ==========================================================
    // led indication select
    if (q_r.conflict) begin
      q_nxt.led = IPSEL_LED_FLASH4;
    end else if (q_r.st == IPSEL_ST_ERASE) begin
      q_nxt.led = q_r.erase_ready ? IPSEL_LED_ON : IPSEL_LED_FLASH2;
    end else begin
      q_nxt.led = q_r.cfg.valid ? IPSEL_LED_ON : IPSEL_LED_OFF;
    end
    // blink cycle: phases 0..7 are flash slots, 8..11 the pause
    if (q_r.blink_cnt >= BLINK_CYC - 1) begin
      q_nxt.blink_cnt = '0;
      q_nxt.blink_ph = (q_r.blink_ph == 4'hb) ? 4'h0 : q_r.blink_ph + 4'h1;
    end else begin
      q_nxt.blink_cnt = q_r.blink_cnt + 32'h1;
    end
    case (q_r.led)
      IPSEL_LED_ON: q_nxt.led_o = 1'b1;
      IPSEL_LED_FLASH2: q_nxt.led_o = (q_r.blink_ph < 4'h4) && !q_r.blink_ph[0];
      IPSEL_LED_FLASH4: q_nxt.led_o = (q_r.blink_ph < 4'h8) && !q_r.blink_ph[0];
      default: q_nxt.led_o = 1'b0;
    endcase
    // ==========================================================
    // register bus; sticky set wins over write-one-clear
    q_nxt.rdata = 32'h0;
    if (reg_wr) begin
      case (reg_addr)
        OFS_STATUS: q_nxt.stat = q_r.stat & ~reg_wdata[`IPSEL_EV_W-1:0];
        OFS_MASK: q_nxt.mask = reg_wdata[`IPSEL_EV_W-1:0];
        // held only; read back at OFS_SWCFG, never applied to the address set
        OFS_SWCFG: q_nxt.sw_cfg = reg_wdata;
        default: begin
        end
      endcase
    end
    q_nxt.stat = q_nxt.stat | ev;
    if (reg_rd) begin
      case (reg_addr)
        OFS_STATUS: q_nxt.rdata = 32'(q_r.stat);
        OFS_MASK: q_nxt.rdata = 32'(q_r.mask);
        OFS_MODE: q_nxt.rdata = {17'h0, q_r.st, q_r.tens_lat, q_r.mode_lat};
        OFS_ADDR: q_nxt.rdata = q_r.cfg.addr;
        OFS_SWCFG: q_nxt.rdata = q_r.sw_cfg;
        default: q_nxt.rdata = 32'h0;
      endcase
    end
    q_nxt.irq_o = |(q_nxt.stat & q_nxt.mask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q_r <= '0;
      q_r.st <= IPSEL_ST_SAMPLE;
      q_r.led <= IPSEL_LED_OFF;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign reg_rdata = q_r.rdata;
  assign dhcp_req = q_r.dreq;
  assign cfg_out = q_r.cfg;
  assign nvm_erase = q_r.erase_p;
  assign status_led = q_r.led_o;
  assign irq = q_r.irq_o;
  // fixed commissioning port, constant from reset
  assign modbus_port = `IPSEL_MODBUS_PORT;
endmodule : ipsel_top
`default_nettype wire

/* verif/ipsel_top_properties.sv */
// Purpose: port checks for the address selector
// Assumes: one clock, rstn async low
// Notes: bound into ipsel_top at the foot
`timescale 1ns/1ps
`default_nettype none
`include "ipsel_defs.svh"
module ipsel_top_properties #(
  parameter int unsigned DHCP_WAIT_CYC = 50,
  parameter int unsigned BLINK_CYC = 4
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire ipsel_pkg::ipsel_cfg_type nvm_cfg,
  input wire logic dhcp_ack,
  input wire logic [31:0] dhcp_addr,
  input wire logic addr_conflict,
  input wire ipsel_pkg::ipsel_dhcp_type dhcp_req,
  input wire ipsel_pkg::ipsel_cfg_type cfg_out,
  input wire logic status_led
);
  import ipsel_pkg::*;
  localparam int FB_MAX = DHCP_WAIT_CYC + 8; // request lifetime with slack
  localparam int LED_MAX = 12 * BLINK_CYC + 4; // one led cycle with slack
  // ====
  // properties, one clock domain
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_offer;
    dhcp_req.req && dhcp_ack;
  endsequence
  sequence s_applied;
    !dhcp_req.req && cfg_out.valid && cfg_out.addr == $past(dhcp_addr);
  endsequence
  property p_take;
    s_offer |=> s_applied;
  endproperty
  a_take: assert property (p_take) else $error("offer not applied");
  property p_fallback;
    $fell(dhcp_req.req) && !$past(dhcp_ack) |-> ##[0:2] cfg_out == nvm_cfg;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no stored fallback");
  property p_req_life;
    $rose(dhcp_req.req) |-> ##[1:FB_MAX] !dhcp_req.req;
  endproperty
  a_req_life: assert property (p_req_life) else $error("request never ends");
  property p_label;
    dhcp_req.req && dhcp_req.by_label |-> dhcp_req.label_digits[23:16] inside {8'h30, 8'h31}
      && dhcp_req.label_digits[15:8] inside {[8'h30:8'h39]}
      && dhcp_req.label_digits[7:0] inside {[8'h30:8'h39]};
  endproperty
  a_label: assert property (p_label) else $error("label not decimal");
  property p_host;
    cfg_out.valid && cfg_out.addr[31:8] == `IPSEL_NET_PREFIX
      |-> cfg_out.addr[7:0] != 8'h00 && cfg_out.addr[7:0] != 8'hff;
  endproperty
  a_host: assert property (p_host) else $error("net or broadcast host");
  property p_hold;
    dhcp_req.req && $past(dhcp_req.req) |-> $stable(dhcp_req);
  endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_quiet;
    $rose(rstn) |-> (!dhcp_req.req && !cfg_out.valid) [*4];
  endproperty
  a_quiet: assert property (p_quiet) else $error("acted before latch");
  property p_conflict;
    $rose(addr_conflict) |-> ##[1:LED_MAX] status_led;
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflict not lit");
endmodule : ipsel_top_properties
bind ipsel_top ipsel_top_properties #(
  .DHCP_WAIT_CYC(DHCP_WAIT_CYC),
  .BLINK_CYC(BLINK_CYC)
) u_ipsel_top_properties (
  .clk_sys(clk_sys), .rstn(rstn), .nvm_cfg(nvm_cfg), .dhcp_ack(dhcp_ack),
  .dhcp_addr(dhcp_addr), .addr_conflict(addr_conflict), .dhcp_req(dhcp_req),
  .cfg_out(cfg_out), .status_led(status_led)
);
`default_nettype wire

/* verif/ipsel_dhcp_server.sv */
// Purpose: behavioural address server facing the selector
// Assumes: same clock, one offer per request
// Notes: lines carry junk outside an offer
`timescale 1ns/1ps
`default_nettype none
module ipsel_dhcp_server (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire ipsel_pkg::ipsel_dhcp_type dhcp_req,
  input wire logic [7:0] mac_last_byte,
  input wire logic silent, // never answer, forces the timeout
  input wire logic [3:0] dly, // answer latency in cycles
  output logic dhcp_ack,
  output ipsel_pkg::ipsel_cfg_type offer
);
  import ipsel_pkg::*;
  logic [3:0] cnt_r; // cycles waited on this request
  logic [31:0] lease; // one address per client key
  assign lease = dhcp_req.by_label ? {8'h0b, dhcp_req.label_digits} : {24'h0a0002, mac_last_byte};
  // ====
  // offer after dly cycles
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 4'h0;
      dhcp_ack <= 1'b0;
      offer <= '0;
    end else if (!dhcp_ack && dhcp_req.req && !silent && cnt_r == dly) begin
      dhcp_ack <= 1'b1;
      offer <= '{lease, 32'hffffff00, {lease[31:8], 8'h01}, 1'b1};
    end else begin
      // toggling lines so stale data cannot pass for an offer
      cnt_r <= (dhcp_req.req && !dhcp_ack) ? cnt_r + 4'h1 : 4'h0;
      dhcp_ack <= 1'b0;
      offer <= ~offer;
    end
  end
endmodule : ipsel_dhcp_server
`default_nettype wire

/* verif/ip_address_switch_selector_test.sv */
// Purpose: self-checking bench for the address selector
// Assumes: fallback wait 50 cycles, led phase 4 cycles
// Notes: the mode is latched once, so each case reboots
`timescale 1ns/1ps
`default_nettype none
module ip_address_switch_selector_test;
  import ipsel_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] mode_sw = 4'h0;
  logic [3:0] tens_sw = 4'h0;
  logic [7:0] mac = 8'h5c;
  logic conflict = 1'b0;
  logic silent = 1'b0;
  logic [3:0] dly = 4'h6;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  ipsel_cfg_type nvm = '{32'h0a0000c8, 32'hffff0000, 32'h0a000001, 1'b1};
  ipsel_cfg_type offer, cfg_out;
  ipsel_dhcp_type dhcp_req;
  logic dhcp_ack, nvm_erase, status_led, irq;
  logic [31:0] reg_rdata;
  logic [15:0] modbus_port;
  int mismatches = 0;
  int comparisons = 0;
  int erases = 0;
  ipsel_top #(.DHCP_WAIT_CYC(50), .BLINK_CYC(4)) u_ipsel_top (
    .clk_sys(clk_sys), .rstn(rstn), .mode_select_switch(mode_sw), .tens_digit_switch(tens_sw),
    .mac_last_byte(mac), .nvm_cfg(nvm), .dhcp_ack(dhcp_ack), .dhcp_addr(offer.addr),
    .dhcp_mask(offer.mask), .dhcp_gw(offer.gw), .addr_conflict(conflict), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dhcp_req(dhcp_req), .cfg_out(cfg_out), .nvm_erase(nvm_erase), .modbus_port(modbus_port),
    .status_led(status_led), .irq(irq));
  ipsel_dhcp_server u_ipsel_dhcp_server (.clk_sys(clk_sys), .rstn(rstn), .dhcp_req(dhcp_req),
    .mac_last_byte(mac), .silent(silent), .dly(dly), .dhcp_ack(dhcp_ack), .offer(offer));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (nvm_erase === 1'b1) erases++;
  // ====
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic boot(input logic [3:0] m, input logic [3:0] t);
    @(posedge clk_sys);
    rstn <= 1'b0;
    mode_sw <= m;
    tens_sw <= t;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    tick(8);
  endtask : boot
  task automatic sw(input logic [3:0] m, input logic [3:0] t);
    @(posedge clk_sys);
    mode_sw <= m;
    tens_sw <= t;
    tick(6);
  endtask : sw
  task automatic wait_on(input bit sel);
    for (int i = 0; i < 200; i++) begin
      if ((sel ? dhcp_req.req : cfg_out.valid) === 1'b1) break;
      tick(1);
    end
  endtask : wait_on
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & msk, exp);
  endtask : rd
  task automatic leds(input logic [31:0] exp);
    int c;
    logic p;
    c = 0;
    p = status_led;
    repeat (48) begin
      tick(1);
      if (status_led === 1'b1 && p !== 1'b1) c++;
      p = status_led;
    end
    chk(c, exp);
  endtask : leds
  // ====
  // scenarios
  task automatic name_case(input logic [3:0] m, input logic [3:0] t, input logic [23:0] lbl);
    boot(m, t);
    wait_on(1);
    chk(dhcp_req.by_label, 1'b1);
    chk(dhcp_req.label_digits, lbl);
    sw(4'ha, 4'h0);
    wait_on(0);
    chk(cfg_out.addr, {8'h0b, lbl});
    rd(8'h08, 32'hff, {t, m});
    $display("name case done");
  endtask : name_case
  task automatic t_mac();
    dly <= 4'h9;
    for (int k = 0; k < 2; k++) begin
      boot(4'ha + 4'(k), 4'(k * 7));
      wait_on(1);
      chk(dhcp_req.by_label, 1'b0);
      wait_on(0);
      chk(cfg_out.addr, {24'h0a0002, mac});
      chk(cfg_out.mask, 32'hffffff00);
      chk(cfg_out.gw, {24'h0a0002, 8'h01});
    end
    $display("mac case done");
  endtask : t_mac
  task automatic t_fallback();
    silent <= 1'b1;
    boot(4'hc, 4'h0);
    wr(8'h04, 32'h0);
    wait_on(0);
    chk(cfg_out.addr, nvm.addr);
    chk(irq, 1'b0);
    wr(8'h04, 32'h2);
    tick(1);
    chk(irq, 1'b1);
    rd(8'h00, 32'h2, 32'h2);
    wr(8'h00, 32'h2);
    tick(1);
    chk(irq, 1'b0);
    wr(8'h10, 32'h0a0a0a0a);
    rd(8'h0c, 32'hffffffff, nvm.addr);
    rd(8'hfc, 32'hffffffff, 32'h0);
    $display("fallback case done");
  endtask : t_fallback
  task automatic t_erase();
    erases = 0;
    boot(4'he, 4'h0);
    chk(erases, 1);
    sw(4'h0, 4'h0);
    chk(cfg_out.valid, 1'b0);
    leds(2);
    sw(4'h9, 4'hf);
    wait_on(0);
    chk(cfg_out.addr, 32'hc0a8649f);
    leds(0);
    chk(status_led, 1'b1);
    sw(4'ha, 4'hf);
    chk(cfg_out.valid, 1'b0);
    rd(8'h00, 32'h8, 32'h8);
    leds(2);
    sw(4'h1, 4'h0);
    wait_on(0);
    chk(cfg_out.addr, 32'hc0a86401);
    $display("erase case done");
  endtask : t_erase
  task automatic t_macder();
    logic [7:0] macs [3] = '{8'h00, 8'hff, 8'ha7};
    logic [7:0] host [3] = '{8'h01, 8'hfe, 8'ha7};
    for (int k = 0; k < 3; k++) begin
      mac <= macs[k];
      boot(4'hf, 4'h5);
      wait_on(0);
      chk(cfg_out.addr, {24'hc0a864, host[k]});
      chk(cfg_out.mask, 32'hffffff00);
      chk(cfg_out.gw, {24'hc0a864, host[k]});
    end
    $display("derived case done");
  endtask : t_macder
  task automatic t_conflict();
    silent <= 1'b0;
    boot(4'hd, 4'h7);
    chk(dhcp_req.req, 1'b0);
    wait_on(0);
    chk(cfg_out.addr, nvm.addr);
    wr(8'h04, 32'h4);
    conflict <= 1'b1;
    tick(4);
    leds(4);
    chk(irq, 1'b1);
    chk(modbus_port, 16'd502);
    $display("conflict case done");
  endtask : t_conflict
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (10000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end
  initial begin
    name_case(4'h3, 4'h5, 24'h303533);
    name_case(4'h9, 4'hf, 24'h313539);
    t_mac();
    t_fallback();
    t_erase();
    t_macder();
    t_conflict();
    test_done();
  end
endmodule : ip_address_switch_selector_test
`default_nettype wire
